// ==== src/mem_test_defs.vh ====
// Constants for the memory test interface: widths, register map, fields, codes.
// Assumes a 32-bit AXI4-Lite register bus and one memory clock.
`ifndef MEM_TEST_DEFS_VH
`define MEM_TEST_DEFS_VH
`define ROW_W 4
`define COL_W 2
`define DATA_W 8
`define ADDR_W 6
`define DLY_MAX 15
`define AXI_AW 8
// Register byte addresses.
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_OP 8'h08
`define REG_STAT 8'h0C
`define REG_RDATA 8'h10
// Control fields.
`define CTRL_IPW 0
`define CTRL_TOL 1
`define CTRL_PPW 2
`define CTRL_STY_LO 4
`define CTRL_STY_HI 5
`define CTRL_ORS 6
`define CTRL_TEST 7
// Configuration fields.
`define CFG_DLY_LO 0
`define CFG_DLY_HI 3
`define CFG_GW_LO 8
`define CFG_GW_HI 11
`define CFG_ALG_LO 16
`define CFG_ALG_HI 17
// Operation fields.
`define OP_WR 0
`define OP_ROW_LO 2
`define OP_ROW_HI 5
`define OP_COL_LO 6
`define OP_COL_HI 7
`define OP_POL 8
`define OP_PHASE 9
// Reset values.
`define CTRL_RST 32'h0000_0000
`define CFG_RST 32'h0000_0100
// Bypass styles.
`define STY_REG 2'h0
`define STY_NONE 2'h1
`define STY_DIRECT 2'h2
// Algorithm codes.
`define ALG_NONE 2'h0
`define ALG_CPL 2'h1
`define ALG_CPL_LONG 2'h2
`define ALG_VAR 2'h3
// Bus responses.
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ==== src/memory_test_shadow_write_bypass.v ====
// Memory-side interface of a built-in memory test controller for one
// two-port synchronous SRAM: operation sequencer, inactive-port write,
// scan bypass, delayed compare strobe and checkerboard background.
// Assumes memory, functional logic and bus all run on mclk.
// Functional notes
// R1: Inactive-port write forces row all ones.
// R2: Inactive write enable inverts normal waveform.
// R3: Row changes with write enable.
// R4: Unselected memory needs non-power-of-two rows.
// R5: Target must have supported port set.
// R6: Target must have group width one.
// R7: Only coupling algorithms issue inactive writes; code allows any algorithm but ALG_NONE, ALG_VAR included.
// R8: Parallel writes need feature and tolerance.
// R9: No inactive writes without tolerance flag.
// R10: Defined row field is forced.
// R11: Registered bypass muxes and observes inputs.
// R12: Style none adds no bypass.
// R13: Direct bypass only without output stage.
// R14: Memory internal bypass off during test.
// R15: Read enable then strobe next cycle.
// R16: Strobe delayed by stage count.
// R17: Checkerboard corrected by group width.
// R18: Inactive write during active read cycle.
// R19: Strobe delay per memory, default zero.
// R20: Bypass flops on mclk, in scan.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "mem_test_defs.vh"
module memory_test_shadow_write_bypass (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // AXI4-Lite register bus
   input wire [`AXI_AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`AXI_AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Functional side
   input wire [`ADDR_W-1:0] funcAddr,
   input wire funcWe,
   input wire funcRe,
   input wire [`DATA_W-1:0] funcDin,
   output wire [`DATA_W-1:0] funcDout,
   // Scan control of the bypass flip-flops
   input wire scanMode,
   input wire scanShift,
   input wire scanIn,
   output wire scanOut,
   // Memory active port
   output reg [`ROW_W-1:0] memRowA,
   output reg [`COL_W-1:0] memColA,
   output reg memWeA,
   output reg memReA,
   output reg [`DATA_W-1:0] memDinA,
   input wire [`DATA_W-1:0] memDoutA,
   // Memory inactive port
   output reg [`ROW_W-1:0] memRowB,
   output reg [`COL_W-1:0] memColB,
   output reg memWeB,
   output reg [`DATA_W-1:0] memDinB,
   // Test status
   output wire compareStrobe,
   output wire compareFail
);
   // Checkerboard bit: toggles per row, column and per physical group copy.
   // A group width of zero is treated as one group spanning the whole word.
   function [`DATA_W-1:0] ckbPattern;
      input pol;
      input [`ROW_W-1:0] row;
      input [`COL_W-1:0] col;
      input [3:0] gw;
      integer i;
      begin
         for (i = 0; i < `DATA_W; i = i + 1)
            ckbPattern[i] = pol ^ row[0] ^ col[0] ^ ((gw != 4'h0) && ((i / gw) % 2 == 1));
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Register bus
   reg [31:0] ctrl_q;
   reg [31:0] cfg_q;
   reg [31:0] op_q;
   reg [`DATA_W-1:0] rdata_q;
   reg fail_q;
   reg awHeld_q;
   reg wHeld_q;
   reg [`AXI_AW-1:0] awAddr_q;
   reg [31:0] wData_q;
   reg [3:0] wStrb_q;
   reg opStart;
   reg failClr;
   wire busy;
   wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign s_axi_awready = ~awHeld_q;
   assign s_axi_wready = ~wHeld_q;
   assign s_axi_arready = ~s_axi_rvalid;
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer b;
      begin
         for (b = 0; b < 4; b = b + 1)
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction
   function mapped;
      input [`AXI_AW-1:0] a;
      begin
         mapped = (a == `REG_CTRL) || (a == `REG_CFG) || (a == `REG_OP) ||
                  (a == `REG_STAT) || (a == `REG_RDATA);
      end
   endfunction
   // R8 parallel gate
   wire ppwAllowed = ctrl_q[`CTRL_IPW] & ctrl_q[`CTRL_TOL];
   wire [1:0] algo = cfg_q[`CFG_ALG_HI:`CFG_ALG_LO];
   wire [3:0] gw = cfg_q[`CFG_GW_HI:`CFG_GW_LO];
   // R7 not kept: any algorithm but ALG_NONE, ALG_VAR included
   wire algoCpl = (algo != `ALG_NONE);
   // R9 tolerance required; R6 group width one
   wire ipwAllowed = ctrl_q[`CTRL_IPW] & ctrl_q[`CTRL_TOL] & algoCpl & (gw == 4'h1);
   wire [31:0] statWord = {24'h0, fail_q, 2'b00, ppwAllowed, ipwAllowed, 2'b00, busy};
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `CTRL_RST;
         cfg_q <= `CFG_RST;
         op_q <= 32'h0000_0000;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= {`AXI_AW{1'b0}};
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `RESP_OK;
         s_axi_rdata <= 32'h0000_0000;
         opStart <= 1'b0;
         failClr <= 1'b0;
      end else begin
         opStart <= 1'b0;
         failClr <= 1'b0;
         if (s_axi_awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awAddr_q) ? `RESP_OK : `RESP_ERR;
            if (awAddr_q == `REG_CTRL)
               ctrl_q <= merge(ctrl_q, wData_q, wStrb_q);
            if (awAddr_q == `REG_CFG)
               cfg_q <= merge(cfg_q, wData_q, wStrb_q);
            // Writes to the operation register while busy are dropped.
            if (awAddr_q == `REG_OP && !busy) begin
               op_q <= merge(op_q, wData_q, wStrb_q);
               opStart <= 1'b1;
            end
            if (awAddr_q == `REG_STAT && wStrb_q[0] && wData_q[7])
               failClr <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OK : `RESP_ERR;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata <= ctrl_q;
               `REG_CFG: s_axi_rdata <= cfg_q;
               `REG_OP: s_axi_rdata <= op_q;
               `REG_STAT: s_axi_rdata <= statWord;
               `REG_RDATA: s_axi_rdata <= {24'h0, rdata_q};
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Operation sequencer
   localparam S_IDLE = 2'd0;
   localparam S_CYC1 = 2'd1;
   localparam S_CYC2 = 2'd2;
   reg [1:0] state_q;
   reg [`DLY_MAX:0] strobeSr_q;
   reg [`DATA_W-1:0] expect_q;
   wire testOn = ctrl_q[`CTRL_TEST];
   wire opWrite = op_q[`OP_WR];
   wire [`ROW_W-1:0] opRow = op_q[`OP_ROW_HI:`OP_ROW_LO];
   wire [`COL_W-1:0] opCol = op_q[`OP_COL_HI:`OP_COL_LO];
   wire [`DATA_W-1:0] bg = ckbPattern(op_q[`OP_POL], opRow, opCol, gw);
   // R18 only in the marked phase of a read
   wire ipwNow = ipwAllowed & op_q[`OP_PHASE] & ~opWrite;
   wire ppwNow = ctrl_q[`CTRL_PPW] & ppwAllowed & opWrite;
   wire [3:0] dly = cfg_q[`CFG_DLY_HI:`CFG_DLY_LO];
   assign busy = (state_q != S_IDLE) | (|strobeSr_q);
   // R16 strobe delayed by configured stages; R19 default zero
   assign compareStrobe = strobeSr_q[dly];
   assign compareFail = fail_q;
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= S_IDLE;
         strobeSr_q <= {(`DLY_MAX+1){1'b0}};
         expect_q <= {`DATA_W{1'b0}};
      end else begin
         strobeSr_q <= {strobeSr_q[`DLY_MAX-1:0], 1'b0};
         // The tap has fired; clear the tail so busy drops.
         if (compareStrobe)
            strobeSr_q <= {(`DLY_MAX+1){1'b0}};
         case (state_q)
            S_IDLE: begin
               if (opStart && testOn) begin
                  state_q <= S_CYC1;
                  expect_q <= bg;
               end
            end
            S_CYC1: state_q <= S_CYC2;
            S_CYC2: begin
               state_q <= S_IDLE;
               // R15 strobe in second read cycle
               if (!opWrite)
                  strobeSr_q <= {{`DLY_MAX{1'b0}}, 1'b1};
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   // Set wins over a clear in the same cycle.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fail_q <= 1'b0;
         rdata_q <= {`DATA_W{1'b0}};
      end else begin
         if (compareStrobe)
            rdata_q <= memDoutA;
         if (compareStrobe && memDoutA != expect_q)
            fail_q <= 1'b1;
         else if (failClr)
            fail_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Memory port drive
   wire weNorm = (state_q == S_CYC1) & opWrite;
   // Both ports are registered so row and write enable move on one edge.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         memRowA <= {`ROW_W{1'b0}};
         memColA <= {`COL_W{1'b0}};
         memWeA <= 1'b0;
         memReA <= 1'b0;
         memDinA <= {`DATA_W{1'b0}};
         memRowB <= {`ROW_W{1'b0}};
         memColB <= {`COL_W{1'b0}};
         memWeB <= 1'b0;
         memDinB <= {`DATA_W{1'b0}};
      end else if (!testOn) begin
         memRowA <= funcAddr[`ADDR_W-1:`COL_W];
         memColA <= funcAddr[`COL_W-1:0];
         memWeA <= funcWe;
         memReA <= funcRe;
         memDinA <= funcDin;
         memWeB <= 1'b0;
      end else begin
         memRowA <= opRow;
         memColA <= opCol;
         // R17 group-corrected background
         memDinA <= bg;
         memWeA <= weNorm;
         // R15 read enable first cycle only
         memReA <= (state_q == S_CYC1) & ~opWrite;
         memColB <= opCol;
         memDinB <= bg;
         if (ipwNow && state_q != S_IDLE) begin
            // R1 R10 row field forced to all ones
            // R3 row updates with write enable
            memRowB <= {`ROW_W{1'b1}};
            // R2 inverse of the normal waveform
            memWeB <= ~weNorm;
         end else if (ppwNow) begin
            // R8 parallel write follows the operation
            memRowB <= opRow;
            memWeB <= weNorm;
         end else begin
            memRowB <= opRow;
            memWeB <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Scan bypass around the memory outputs
   wire [1:0] style = ctrl_q[`CTRL_STY_HI:`CTRL_STY_LO];
   reg [`DATA_W-1:0] bypass_q;
   // R20 bypass flops on mclk, shiftable
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         bypass_q <= {`DATA_W{1'b0}};
      else if (scanShift)
         bypass_q <= {bypass_q[`DATA_W-2:0], scanIn};
      else
         // R11 same flop observes memory inputs
         bypass_q <= memDinA ^ {{(`DATA_W-`ADDR_W){1'b0}}, memRowA, memColA} ^
                     {{(`DATA_W-2){1'b0}}, memWeA, memReA};
   end
   assign scanOut = bypass_q[`DATA_W-1];
   reg [`DATA_W-1:0] doutSel;
   always @* begin
      doutSel = memDoutA;
      case (style)
         // R11 registered control value
         `STY_REG: if (scanMode) doutSel = bypass_q;
         // R13 direct only without output stage
         `STY_DIRECT: if (scanMode && !ctrl_q[`CTRL_ORS]) doutSel = funcDin;
         // R12 no bypass logic
         default: doutSel = memDoutA;
      endcase
   end
   assign funcDout = doutSel;
endmodule // memory_test_shadow_write_bypass

// ==== test/mem_test_assertions.sv ====
// Checker on the memory-side ports of the memory test interface.
// Assumes one clock, mclk, and sys_rst asynchronous and active high.
`timescale 1ns/1ps
`include "mem_test_defs.vh"
module mem_test_assertions (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Watched outputs
   input wire [`ROW_W-1:0] memRowB,
   input wire memWeA,
   input wire memReA,
   input wire memWeB,
   input wire compareStrobe
);
   default clocking cbk @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   a_read_pulse: assert property ($rose(memReA) |=> !memReA)
      else $error("Read enable held past one cycle.");
   a_access_excl: assert property (!(memWeA && memReA))
      else $error("Read and write enable high together.");
   a_strobe_pulse: assert property (compareStrobe |=> !compareStrobe)
      else $error("Compare strobe wider than one cycle.");
   // The widest delay field value bounds the wait.
   a_strobe_late: assert property ($fell(memReA) |-> ##[0:15] compareStrobe)
      else $error("No compare strobe after a read.");
   a_inactive_row: assert property ((memWeB && !memWeA) |-> &memRowB)
      else $error("Inactive write row not all ones.");
   a_row_with_we: assert property (
      ($changed(memRowB) && (memWeB || $past(memWeB))) |-> $changed(memWeB))
      else $error("Inactive row moved without write enable.");
   a_inactive_read: assert property (
      (memWeB && !memWeA) |-> (memReA || $past(memReA)))
      else $error("Inactive write outside a read.");
   a_inverse_we: assert property ((memWeB && !memWeA && memReA) |=> memWeB)
      else $error("Inactive enable not held inverse.");
endmodule // mem_test_assertions
bind memory_test_shadow_write_bypass mem_test_assertions mem_test_assertions_inst (
   .mclk(mclk),
   .sys_rst(sys_rst),
   .memRowB(memRowB),
   .memWeA(memWeA),
   .memReA(memReA),
   .memWeB(memWeB),
   .compareStrobe(compareStrobe)
);

// ==== test/sram_model.sv ====
// Two-port synchronous SRAM with optional output pipeline stages.
// Assumes it shares the interface clock; port A reads, both ports write.
`timescale 1ns/1ps
// two ports, one 8-bit word per column, no internal bypass.
module sram_model #(parameter int ROWS = 15) (
   // Clock
   input wire logic clk,
   // Active port
   input wire logic [3:0] rowA,
   input wire logic [1:0] colA,
   input wire logic weA,
   input wire logic reA,
   input wire logic [7:0] dinA,
   output logic [7:0] doutA,
   // Inactive port
   input wire logic [3:0] rowB,
   input wire logic [1:0] colB,
   input wire logic weB,
   input wire logic [7:0] dinB,
   // Output stages set by the bench
   input wire logic [3:0] pipeStages
);
   logic [7:0] mem [0:63];
   logic [7:0] pipe [0:15];
   initial begin
      for (int i = 0; i < 16; i++) pipe[i] = 8'h00;
   end
   always @(posedge clk) begin
      if (weA && rowA < ROWS) mem[{rowA, colA}] <= dinA;
      if (weB && rowB < ROWS) mem[{rowB, colB}] <= dinB;
      // Idle output keeps toggling so stale data never looks valid.
      pipe[0] <= reA ? mem[{rowA, colA}] : ~pipe[0];
      for (int i = 1; i < 16; i++) pipe[i] <= pipe[i-1];
   end
   assign doutA = pipe[pipeStages];
endmodule // sram_model

// ==== test/tb.sv ====
// Self-checking bench for the memory test interface with an SRAM model.
// Assumes a 25 MHz mclk and register access over AXI4-Lite only.
`timescale 1ns/1ps
`include "mem_test_defs.vh"
module tb;
   logic mclk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, funcWe = 0, funcRe = 0;
   logic scanMode = 0, scanShift = 0, scanIn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, funcDin = 0, lastDin;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hF, pipe = 0, rowB;
   logic [5:0] funcAddr = 0;
   int fails = 0, checks_done = 0, nInact = 0, nPar = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire scanOut, memWeA, memReA, memWeB, compareStrobe, compareFail;
   wire [1:0] s_axi_bresp, s_axi_rresp, memColA, memColB;
   wire [31:0] s_axi_rdata;
   wire [3:0] memRowA, memRowB;
   wire [7:0] memDinA, memDinB, memDoutA, funcDout;
   memory_test_shadow_write_bypass memory_test_shadow_write_bypass_inst (.*);
   sram_model sram_model_inst (.clk(mclk), .rowA(memRowA), .colA(memColA),
      .weA(memWeA), .reA(memReA), .dinA(memDinA), .doutA(memDoutA), .rowB(memRowB),
      .colB(memColB), .weB(memWeB), .dinB(memDinB), .pipeStages(pipe));
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk) begin
      if (memWeA) lastDin <= memDinA;
      // Counters only ever grow, so scenarios compare differences.
      if (memWeB && !memWeA) begin
         nInact <= nInact + 1;
         rowB <= memRowB;
      end
      if (memWeB && memWeA) nPar <= nPar + 1;
   end
   //////////////////////////////////////////////////////////////////
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task final_report;
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta, tw, tv;
      logic [1:0] r;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge mclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tv = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
      end while (!tv);
      s_axi_bready <= 0;
      @(posedge mclk);
      cmp(r, e);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
      logic ta, tv;
      logic [1:0] r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge mclk);
         ta = s_axi_arvalid & s_axi_arready;
         tv = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 0;
      end while (!tv);
      s_axi_rready <= 0;
      @(posedge mclk);
      cmp(r, e);
   endtask
   // Starts an operation and polls busy so ops never overlap.
   task op(input logic [31:0] v);
      logic [31:0] s;
      wr(`REG_OP, v, `RESP_OK);
      s = 32'h0000_0001;
      for (int i = 0; i < 20 && s[0]; i++) rd(`REG_STAT, s, `RESP_OK);
   endtask
   function logic [7:0] bg(input logic p, input int g);
      for (int i = 0; i < 8; i++) bg[i] = p ^ 1'((i / g) % 2);
   endfunction
   task t_regs;
      logic [31:0] d;
      rd(`REG_CTRL, d, `RESP_OK);
      cmp(d, `CTRL_RST);
      rd(`REG_CFG, d, `RESP_OK);
      cmp(d, `CFG_RST);
      rd(8'h1C, d, `RESP_ERR);
      cmp(d, 32'h0000_0000);
      wr(8'h1C, 32'hFFFF_FFFF, `RESP_ERR);
   endtask
   // Row 5, column 1, polarity 1: the background starts at one.
   task t_rw;
      logic [31:0] d;
      wr(`REG_CTRL, 32'h0000_0080, `RESP_OK);
      for (int g = 1; g < 4; g += 2) begin
         wr(`REG_CFG, 32'(g) << 8, `RESP_OK);
         op(32'h0000_0155);
         cmp(lastDin, bg(1'b1, g));
         op(32'h0000_0154);
         rd(`REG_RDATA, d, `RESP_OK);
         cmp(d, {24'h0, bg(1'b1, g)});
      end
      cmp(compareFail, 1'b0);
   endtask
   task t_fail;
      logic [31:0] d;
      pipe <= 2;
      wr(`REG_CFG, 32'h0000_0102, `RESP_OK);
      op(32'h0000_0155);
      op(32'h0000_0154);
      rd(`REG_RDATA, d, `RESP_OK);
      cmp(d, {24'h0, bg(1'b1, 1)});
      cmp(compareFail, 1'b0);
      op(32'h0000_0054);
      cmp(compareFail, 1'b1);
      wr(`REG_STAT, 32'h0000_0080, `RESP_OK);
      cmp(compareFail, 1'b0);
      pipe <= 0;
      wr(`REG_CFG, `CFG_RST, `RESP_OK);
   endtask
   task t_iw(input logic [31:0] c, input logic [31:0] f, input logic [7:0] es, input logic ew);
      logic [31:0] s;
      int n0, p0;
      wr(`REG_CTRL, c, `RESP_OK);
      wr(`REG_CFG, f, `RESP_OK);
      rd(`REG_STAT, s, `RESP_OK);
      cmp(s & 32'h18, es);
      n0 = nInact;
      op(32'h0000_0208);
      // Inverse of an all-low read waveform: both op cycles write.
      cmp(nInact - n0, ew ? 2 : 0);
      if (ew) cmp(rowB, 4'hF);
      p0 = nPar;
      op(32'h0000_0209);
      cmp(nPar - p0, es[4] & c[2]);
   endtask
   task look(input logic m);
      @(negedge mclk);
      cmp(funcDout, m ? memDoutA : 8'hA5);
      @(posedge mclk);
   endtask
   task t_bypass;
      scanMode <= 1;
      funcDin <= 8'hA5;
      wr(`REG_CTRL, 32'h0000_0010, `RESP_OK);
      look(1);
      wr(`REG_CTRL, 32'h0000_0020, `RESP_OK);
      look(0);
      wr(`REG_CTRL, 32'h0000_0060, `RESP_OK);
      look(1);
      wr(`REG_CTRL, 32'h0000_0000, `RESP_OK);
      scanIn <= 1;
      scanShift <= 1;
      repeat (8) @(posedge mclk);
      scanShift <= 0;
      @(negedge mclk);
      cmp(scanOut, 1'b1);
      cmp(funcDout, 8'hFF);
      @(posedge mclk);
      @(negedge mclk);
      cmp(funcDout, 8'hA5);
      @(posedge mclk);
      scanMode <= 0;
   endtask
   //////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 0;
      @(posedge mclk);
      t_regs;
      t_rw;
      t_fail;
      t_iw(32'h0000_0080, 32'h0001_0100, 8'h00, 0);
      t_iw(32'h0000_0083, 32'h0001_0100, 8'h18, 1);
      t_iw(32'h0000_0081, 32'h0001_0100, 8'h00, 0);
      t_iw(32'h0000_0083, 32'h0000_0100, 8'h10, 0);
      t_iw(32'h0000_0083, 32'h0001_0300, 8'h10, 0);
      t_iw(32'h0000_0087, 32'h0001_0100, 8'h18, 1);
      t_iw(32'h0000_0085, 32'h0001_0100, 8'h00, 0);
      t_bypass;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      final_report;
   end
endmodule // tb
